// ==== hdl/evmon_defs.vh ====
// Constants for the event priority and validity monitor: register map, fields, timing.
// Assumes a single 200 MHz clock and a 32-bit AXI4-Lite register bus.
`ifndef EVMON_DEFS_VH
`define EVMON_DEFS_VH
// ********************
// Register byte offsets
// ********************
`define REG_CTRL            8'h00
`define REG_FREEZE_INTERVAL 8'h04
`define REG_SET_PERIOD      8'h08
`define REG_CHECK_INTERVAL  8'h0C
`define REG_FAIL_THRESHOLD  8'h10
`define REG_PRIO_MAP        8'h14
`define REG_IRQ_STATUS      8'h18
`define REG_IRQ_CLEAR       8'h1C
`define REG_IRQ_ENABLE      8'h20
`define REG_POINT_MONITORED 8'h24
`define REG_FLAG_CLEAR      8'h28
`define REG_FLAGS           8'h2C
`define REG_INVALID         8'h30
`define REG_QUEUE_STATUS    8'h34
// ********************
// Fields and reset values
// ********************
`define CTRL_PRIO_EN      0
`define CTRL_START_LSB    1
`define CTRL_START_MSB    2
`define START_NOT_USED    2'h0
`define IRQ_FREEZE        0
`define IRQ_WENT_INVALID  1
`define IRQ_OVERFLOW      2
`define IRQ_WENT_VALID    3
`define IRQ_BITS          4
`define PRIO_MAP_RESET    24'hFAC688
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
// ********************
// Timing
// ********************
`define SECOND_NS         1000000000
`define CLK_PERIOD_NS     5
`endif

// ==== hdl/event_priority_validity_monitor.v ====
// Event priority scheduler, counter freeze timer and invalid-flag monitor with an AXI4-Lite
// register file. Assumes event and flag-clear inputs come from logic on the same clock.
//
// What this block does
// R1 - Freeze interval 0..65535 s; periodic freeze when start type and interval set.
// R2 - Priority ordering applies only while the priority-queue enable is set.
// R3 - Software gives each data type a distinct priority index 0..7.
// R4 - Smaller priority index is more urgent; 0 most, 7 least.
// R5 - All pending events of a more urgent queue go out before less urgent ones.
// R6 - Each queue has its own buffer; a starved queue may overflow and drop.
// R7 - Each data type holds its own independent priority setting.
// R8 - Every set period (1..65535 s) sets flags of all monitored points.
// R9 - At each check interval, failure count rises for points with flag set.
// R10 - Count reaching threshold marks point invalid in replies.
// R11 - Flag found clear before threshold resets count and reports valid.
// R12 - Any of set period, check interval, threshold zero disables checking.
// R13 - Points with zero flag address are excluded from set, check and report.
// R14 - The application writes flags and clears valid ones often enough.
// R15 - Software should make set period well above check interval times threshold.
// R16 - Checks run every check interval, 1..65535 s, on monitored points.
// R17 - All second periods derive from one one-second tick after reset.
`timescale 1ns/1ps
`default_nettype none
`include "evmon_defs.vh"
module event_priority_validity_monitor #(
    parameter NUM_POINTS  = 8,
    parameter QUEUE_DEPTH = 16,
    parameter TICK_CYCLES = `SECOND_NS / `CLK_PERIOD_NS
) (
    // Clock and reset
    input  wire                  aclk,
    input  wire                  aresetn,
    // AXI4-Lite slave
    input  wire [7:0]            s_axi_awaddr,
    input  wire                  s_axi_awvalid,
    output reg                   s_axi_awready,
    input  wire [31:0]           s_axi_wdata,
    input  wire [3:0]            s_axi_wstrb,
    input  wire                  s_axi_wvalid,
    output reg                   s_axi_wready,
    output reg  [1:0]            s_axi_bresp,
    output reg                   s_axi_bvalid,
    input  wire                  s_axi_bready,
    input  wire [7:0]            s_axi_araddr,
    input  wire                  s_axi_arvalid,
    output reg                   s_axi_arready,
    output reg  [31:0]           s_axi_rdata,
    output reg  [1:0]            s_axi_rresp,
    output reg                   s_axi_rvalid,
    input  wire                  s_axi_rready,
    // Data-change events, one pulse per event, one bit per data type
    input  wire [7:0]            event_in,
    // Report port toward the master side
    output reg                   report_valid_q,
    output reg  [2:0]            report_type_q,
    input  wire                  report_ready,
    // Application clears of point flags
    input  wire [NUM_POINTS-1:0] flag_clear,
    // Status toward the master side
    output reg  [NUM_POINTS-1:0] point_invalid_q,
    output reg                   freeze_periodic_q,
    output reg                   freeze_pulse_q,
    output reg                   irq_q
);
    localparam CW = $clog2(QUEUE_DEPTH + 1);
    localparam TW = $clog2(TICK_CYCLES + 1);

    // ********************
    // Registers
    // ********************
    reg [2:0]             ctrl_q;
    reg [15:0]            freeze_interval_q;
    reg [15:0]            set_period_q;
    reg [15:0]            check_interval_q;
    reg [15:0]            fail_threshold_q;
    reg [23:0]            prio_map_q;
    reg [`IRQ_BITS-1:0]   irq_status_q;
    reg [`IRQ_BITS-1:0]   irq_enable_q;
    reg [NUM_POINTS-1:0]  monitored_q;
    reg [NUM_POINTS-1:0]  flag_q;
    reg                   aw_held_q;
    reg                   w_held_q;
    reg [7:0]             awaddr_q;
    reg [31:0]            wdata_q;
    reg [3:0]             wstrb_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;
    wire wr_go   = aw_held_q & w_held_q & ~s_axi_bvalid;
    wire [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
    wire [31:0] wval = wdata_q & wmask;

    // ********************
    // One-second tick and period timers
    // ********************
    reg [TW-1:0] tick_cnt_q;
    reg          tick_q;
    reg [15:0]   freeze_cnt_q;
    reg [15:0]   set_cnt_q;
    reg [15:0]   check_cnt_q;
    wire         tick_end = (tick_cnt_q == TICK_CYCLES[TW-1:0] - 1'b1);

    wire checking  = (set_period_q != 16'h0000) & (check_interval_q != 16'h0000)
                   & (fail_threshold_q != 16'h0000); // see R12
    wire periodic  = (ctrl_q[`CTRL_START_MSB:`CTRL_START_LSB] != `START_NOT_USED)
                   & (freeze_interval_q != 16'h0000); // see R1
    wire set_now   = checking & tick_q & (set_cnt_q == set_period_q - 16'h0001); // see R8
    wire check_now = checking & tick_q & (check_cnt_q == check_interval_q - 16'h0001); // see R16

    always @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q        <= {TW{1'b0}};
            tick_q            <= 1'b0;
            freeze_cnt_q      <= 16'h0000;
            set_cnt_q         <= 16'h0000;
            check_cnt_q       <= 16'h0000;
            freeze_periodic_q <= 1'b0;
            freeze_pulse_q    <= 1'b0;
        end else begin
            tick_q     <= tick_end; // see R17
            tick_cnt_q <= tick_end ? {TW{1'b0}} : tick_cnt_q + 1'b1;
            freeze_periodic_q <= periodic; // see R1
            freeze_pulse_q    <= 1'b0;
            if (!periodic) begin
                freeze_cnt_q <= 16'h0000;
            end else if (tick_q) begin
                if (freeze_cnt_q == freeze_interval_q - 16'h0001) begin
                    freeze_cnt_q   <= 16'h0000;
                    freeze_pulse_q <= 1'b1;
                end else begin
                    freeze_cnt_q <= freeze_cnt_q + 16'h0001;
                end
            end
            // A live retune may stretch one interval; cheaper than a second comparator.
            if (!checking) begin
                set_cnt_q   <= 16'h0000;
                check_cnt_q <= 16'h0000;
            end else if (tick_q) begin
                set_cnt_q   <= set_now ? 16'h0000 : set_cnt_q + 16'h0001;
                check_cnt_q <= check_now ? 16'h0000 : check_cnt_q + 16'h0001;
            end
        end
    end

    // ********************
    // Per-point validity monitor
    // ********************
    wire [NUM_POINTS-1:0] went_invalid;
    wire [NUM_POINTS-1:0] went_valid;
    wire [NUM_POINTS-1:0] sw_clear = (wr_go & (awaddr_q == `REG_FLAG_CLEAR))
                                   ? wval[NUM_POINTS-1:0] : {NUM_POINTS{1'b0}};
    genvar p;
    generate
        for (p = 0; p < NUM_POINTS; p = p + 1) begin : g_point
            reg [15:0] fail_cnt_q;
            wire mon = checking & monitored_q[p]; // see R13
            assign went_invalid[p] = mon & check_now & flag_q[p] & ~point_invalid_q[p]
                                   & (fail_cnt_q + 16'h0001 == fail_threshold_q);
            assign went_valid[p]   = mon & check_now & ~flag_q[p] & point_invalid_q[p];
            always @(posedge aclk) begin
                if (!aresetn) begin
                    flag_q[p]          <= 1'b0;
                    fail_cnt_q         <= 16'h0000;
                    point_invalid_q[p] <= 1'b0;
                end else begin
                    // The periodic set wins over a clear landing in the same cycle.
                    if (mon & set_now) begin
                        flag_q[p] <= 1'b1; // see R8
                    end else if (flag_clear[p] | sw_clear[p]) begin
                        flag_q[p] <= 1'b0;
                    end
                    if (!mon) begin
                        fail_cnt_q         <= 16'h0000;
                        point_invalid_q[p] <= 1'b0; // see R12
                    end else if (check_now) begin
                        if (flag_q[p]) begin
                            if (fail_cnt_q != fail_threshold_q) begin
                                fail_cnt_q <= fail_cnt_q + 16'h0001; // see R9
                            end
                            if (fail_cnt_q + 16'h0001 >= fail_threshold_q) begin
                                point_invalid_q[p] <= 1'b1; // see R10
                            end
                        end else begin
                            fail_cnt_q         <= 16'h0000; // see R11
                            point_invalid_q[p] <= 1'b0;
                        end
                    end
                end
            end
        end
    endgenerate

    // ********************
    // Priority queues, one pending counter per queue
    // ********************
    wire [7:0] q_hit [0:7];
    wire [7:0] q_busy;
    wire [7:0] q_over;
    wire [7:0] q_avail;
    reg  [2:0] rr_q;
    reg  [2:0] pick;
    reg        pick_ok;
    reg  [3:0] k;
    wire       pop = report_valid_q & report_ready;
    genvar q;
    generate
        for (q = 0; q < 8; q = q + 1) begin : g_queue
            reg [CW-1:0] pend_q;
            // Queue q takes the types mapped to it, or type q when ordering is off.
            genvar t;
            for (t = 0; t < 8; t = t + 1) begin : g_map
                assign q_hit[q][t] = event_in[t] & (ctrl_q[`CTRL_PRIO_EN]
                                   ? (prio_map_q[3*t+2:3*t] == q) : (t == q)); // see R7
            end
            wire push = |q_hit[q];
            wire take = pop & (report_type_q == q);
            assign q_busy[q] = (pend_q != {CW{1'b0}});
            assign q_avail[q] = q_busy[q]
                              & ~(take & ~push & (pend_q == {{(CW-1){1'b0}}, 1'b1}));
            assign q_over[q] = push & ~take & (pend_q == QUEUE_DEPTH[CW-1:0]); // see R6
            always @(posedge aclk) begin
                if (!aresetn) begin
                    pend_q <= {CW{1'b0}};
                end else if (push & ~take & ~q_over[q]) begin
                    pend_q <= pend_q + 1'b1;
                end else if (take & ~push) begin
                    pend_q <= pend_q - 1'b1;
                end
            end
        end
    endgenerate

    // With ordering off a rotating pointer gives no queue lasting precedence.
    always @* begin
        pick    = 3'h0;
        pick_ok = 1'b0;
        for (k = 4'h0; k < 4'h8; k = k + 4'h1) begin
            if (ctrl_q[`CTRL_PRIO_EN]) begin
                if (!pick_ok && q_avail[k[2:0]]) begin
                    pick    = k[2:0]; // see R4
                    pick_ok = 1'b1;   // see R5
                end
            end else if (!pick_ok && q_avail[rr_q + k[2:0]]) begin
                pick    = rr_q + k[2:0]; // see R2
                pick_ok = 1'b1;
            end
        end
    end

    // A queue whose last event is being taken is not offered again.
    always @(posedge aclk) begin
        if (!aresetn) begin
            report_valid_q <= 1'b0;
            report_type_q  <= 3'h0;
            rr_q           <= 3'h0;
        end else if (!report_valid_q || pop) begin
            report_valid_q <= pick_ok;
            report_type_q  <= pick;
            if (pick_ok) begin
                rr_q <= pick + 3'h1;
            end
        end
    end

    // ********************
    // Interrupts
    // ********************
    wire [`IRQ_BITS-1:0] irq_set = {|went_valid, |q_over, |went_invalid, freeze_pulse_q};
    wire [`IRQ_BITS-1:0] irq_clr = (wr_go & (awaddr_q == `REG_IRQ_CLEAR))
                                 ? wval[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_status_q <= {`IRQ_BITS{1'b0}};
            irq_q        <= 1'b0;
        end else begin
            irq_status_q <= (irq_status_q & ~irq_clr) | irq_set;
            irq_q        <= |(irq_status_q & irq_enable_q);
        end
    end

    // ********************
    // AXI4-Lite write side
    // ********************
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q         <= 1'b0;
            w_held_q          <= 1'b0;
            awaddr_q          <= 8'h00;
            wdata_q           <= 32'h0000_0000;
            wstrb_q           <= 4'h0;
            s_axi_awready     <= 1'b0;
            s_axi_wready      <= 1'b0;
            s_axi_bvalid      <= 1'b0;
            s_axi_bresp       <= `RESP_OKAY;
            ctrl_q            <= 3'h0;
            freeze_interval_q <= 16'h0000;
            set_period_q      <= 16'h0000;
            check_interval_q  <= 16'h0000;
            fail_threshold_q  <= 16'h0000;
            prio_map_q        <= `PRIO_MAP_RESET;
            irq_enable_q      <= {`IRQ_BITS{1'b0}};
            monitored_q       <= {NUM_POINTS{1'b0}};
        end else begin
            s_axi_awready <= ~aw_held_q & ~aw_take & ~s_axi_bvalid;
            s_axi_wready  <= ~w_held_q & ~w_take & ~s_axi_bvalid;
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                case (awaddr_q)
                    `REG_CTRL:            ctrl_q <= (ctrl_q & ~wmask[2:0]) | wval[2:0];
                    `REG_FREEZE_INTERVAL: freeze_interval_q <= (freeze_interval_q
                                          & ~wmask[15:0]) | wval[15:0]; // see R1
                    `REG_SET_PERIOD:      set_period_q <= (set_period_q & ~wmask[15:0])
                                          | wval[15:0];
                    `REG_CHECK_INTERVAL:  check_interval_q <= (check_interval_q
                                          & ~wmask[15:0]) | wval[15:0];
                    `REG_FAIL_THRESHOLD:  fail_threshold_q <= (fail_threshold_q
                                          & ~wmask[15:0]) | wval[15:0];
                    `REG_PRIO_MAP:        prio_map_q <= (prio_map_q & ~wmask[23:0])
                                          | wval[23:0]; // see R7
                    `REG_IRQ_ENABLE:      irq_enable_q <= wval[`IRQ_BITS-1:0];
                    `REG_POINT_MONITORED: monitored_q <= wval[NUM_POINTS-1:0]; // see R13
                    `REG_IRQ_CLEAR, `REG_FLAG_CLEAR: s_axi_bresp <= `RESP_OKAY;
                    default:              s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ********************
    // AXI4-Lite read side
    // ********************
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case (s_axi_araddr)
                    `REG_CTRL:            s_axi_rdata <= {29'h0, ctrl_q};
                    `REG_FREEZE_INTERVAL: s_axi_rdata <= {16'h0000, freeze_interval_q};
                    `REG_SET_PERIOD:      s_axi_rdata <= {16'h0000, set_period_q};
                    `REG_CHECK_INTERVAL:  s_axi_rdata <= {16'h0000, check_interval_q};
                    `REG_FAIL_THRESHOLD:  s_axi_rdata <= {16'h0000, fail_threshold_q};
                    `REG_PRIO_MAP:        s_axi_rdata <= {8'h00, prio_map_q};
                    `REG_IRQ_STATUS:      s_axi_rdata <= {{(32-`IRQ_BITS){1'b0}}, irq_status_q};
                    `REG_IRQ_ENABLE:      s_axi_rdata <= {{(32-`IRQ_BITS){1'b0}}, irq_enable_q};
                    `REG_POINT_MONITORED: s_axi_rdata <= {{(32-NUM_POINTS){1'b0}}, monitored_q};
                    `REG_FLAGS:           s_axi_rdata <= {{(32-NUM_POINTS){1'b0}}, flag_q};
                    `REG_INVALID:         s_axi_rdata <= {{(32-NUM_POINTS){1'b0}},
                                                          point_invalid_q};
                    `REG_QUEUE_STATUS:    s_axi_rdata <= {15'h0000, checking, q_over, q_busy};
                    `REG_IRQ_CLEAR, `REG_FLAG_CLEAR: s_axi_rdata <= 32'h0000_0000;
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= `RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule // event_priority_validity_monitor
`default_nettype wire

// ==== tb/evmon_properties.sv ====
// Port-level checker for the event priority and validity monitor.
// Assumes it is bound into the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module evmon_checker #(
    parameter NUM_POINTS = 8
) (
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // Register bus handshakes
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    // Event and report side
    input wire logic [7:0]            event_in,
    input wire logic                  report_valid_q,
    input wire logic [2:0]            report_type_q,
    input wire logic                  report_ready,
    // Status outputs
    input wire logic [NUM_POINTS-1:0] point_invalid_q,
    input wire logic                  freeze_periodic_q,
    input wire logic                  freeze_pulse_q,
    input wire logic                  irq_q
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ********************
    // Properties
    // ********************
    reset_clear_a: assert property (disable iff (1'b0) !aresetn |=> !report_valid_q && !irq_q
        && point_invalid_q == '0 && !freeze_pulse_q) else $error("outputs set after reset");
    stall_hold_a: assert property (report_valid_q && !report_ready |=>
        report_valid_q && $stable(report_type_q)) else $error("offer changed while stalled");
    event_offer_a: assert property (event_in != 8'h00 && !report_valid_q |->
        ##[1:2] report_valid_q) else $error("event not offered");
    pulse_mode_a: assert property (freeze_pulse_q |-> freeze_periodic_q)
        else $error("freeze pulse in default mode");
    pulse_gap_a: assert property (freeze_pulse_q |=> !freeze_pulse_q [*8])
        else $error("freeze pulses too close");
    invalid_steady_a: assert property ($changed(point_invalid_q) |=>
        $stable(point_invalid_q) [*8]) else $error("invalid flags change off check");
    write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write taken while response pending");
    read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while response pending");
    cover property (report_valid_q && report_ready);
    cover property (freeze_pulse_q);
    cover property ($rose(point_invalid_q[0]));
endmodule // evmon_checker
bind event_priority_validity_monitor evmon_checker #(.NUM_POINTS(NUM_POINTS)) chk_i (.*);
`default_nettype wire

// ==== tb/report_sink.sv ====
// Model of the remote master taking reports off the report port.
// Assumes the bench stalls it through hold; it logs every report taken.
`timescale 1ns/1ps
`default_nettype none
module report_sink (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Report port
    input wire logic        report_valid_q,
    input wire logic [2:0]  report_type_q,
    output var logic        report_ready,
    // Bench control and log
    input wire logic        hold,
    output var logic        got,
    output var logic [2:0]  got_type
);
    // A stalled master lets queues fill, which is how starvation is provoked.
    always @(posedge aclk) begin
        report_ready <= aresetn && !hold;
        got <= aresetn && report_valid_q && report_ready;
        got_type <= report_type_q;
    end
endmodule // report_sink
`default_nettype wire

// ==== tb/tb_event_priority_validity_monitor.sv ====
// Self-checking bench for the event priority and validity monitor.
// Assumes the defs header on the include path and a one-second tick of 20 cycles.
`timescale 1ns/1ps
`default_nettype none
`include "evmon_defs.vh"
module tb_event_priority_validity_monitor;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, report_valid_q, report_ready, freeze_periodic_q, freeze_pulse_q;
    logic irq_q, hold, got;
    logic [7:0] s_axi_awaddr, s_axi_araddr, event_in, flag_clear, point_invalid_q;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] report_type_q, got_type;
    logic [2:0] seen[$];
    int checked, err_total, n;
    event_priority_validity_monitor #(.NUM_POINTS(8), .QUEUE_DEPTH(2), .TICK_CYCLES(20)) DUT (.*);
    report_sink sink (.aclk(aclk), .aresetn(aresetn), .report_valid_q(report_valid_q),
        .report_type_q(report_type_q), .report_ready(report_ready), .hold(hold),
        .got(got), .got_type(got_type));
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    always @(posedge aclk) if (got === 1'b1) seen.push_back(got_type);
    // ********************
    // Tasks
    // ********************
    task automatic finish_test;
        $display("checked %0d err_total %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, e);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            n++;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        if (n >= 50) begin
            err_total++;
            finish_test();
        end
        chk(s_axi_bresp, r);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_rready <= 1'b0;
        if (n >= 50) begin
            err_total++;
            finish_test();
        end
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, `RESP_OKAY);
    endtask
    task automatic pulse(input logic [7:0] ev);
        @(posedge aclk);
        event_in <= ev;
        @(posedge aclk);
        event_in <= 8'h00;
    endtask
    task automatic drain(input logic [23:0] e, input int c);
        @(posedge aclk);
        hold <= 1'b0;
        repeat (40) @(posedge aclk);
        hold <= 1'b1;
        chk(seen.size(), c);
        for (int i = 0; i < c; i++) chk(seen[i], e[3*i+:3]);
        seen.delete();
    endtask
    task automatic run(input int k, input logic [7:0] c);
        for (int i = 1; i <= k; i++) begin
            @(posedge aclk);
            flag_clear <= (i % 10 == 0) ? c : 8'h00;
        end
        @(posedge aclk);
        flag_clear <= 8'h00;
    endtask
    // ********************
    // Main sequence
    // ********************
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
        {s_axi_rready, s_axi_awaddr, s_axi_araddr, event_in, flag_clear, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        hold = 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`REG_PRIO_MAP, 32'h00FAC688);
        rd(`REG_CTRL, 32'h00000000);
        wr(8'hFC, 32'h00000001, `RESP_SLVERR);
        wr(`REG_PRIO_MAP, 32'h00053977);
        wr(`REG_CTRL, 32'h00000001);
        pulse(8'hFF);
        drain(24'hFAC688, 8);
        pulse(8'h06);
        drain(24'h000035, 2);
        wr(`REG_CTRL, 32'h00000000);
        pulse(8'h06);
        drain(24'h000011, 2);
        repeat (3) pulse(8'h02);
        wr(`REG_IRQ_ENABLE, 32'h00000004);
        rd(`REG_IRQ_STATUS, 32'h00000004);
        chk(irq_q, 1'b1);
        wr(`REG_IRQ_CLEAR, 32'h00000004);
        repeat (2) @(posedge aclk);
        chk(irq_q, 1'b0);
        drain(24'h000009, 2);
        wr(`REG_FREEZE_INTERVAL, 32'h00000002);
        wr(`REG_CTRL, 32'h00000003);
        rd(`REG_CTRL, 32'h00000003);
        chk(freeze_periodic_q, 1'b1);
        for (n = 0; n < 100 && freeze_pulse_q !== 1'b1; n++) @(posedge aclk);
        @(posedge aclk);
        for (n = 1; n < 100 && freeze_pulse_q !== 1'b1; n++) @(posedge aclk);
        chk(n, 40);
        wr(`REG_CTRL, 32'h00000001);
        rd(`REG_CTRL, 32'h00000001);
        chk(freeze_periodic_q, 1'b0);
        wr(`REG_POINT_MONITORED, 32'h00000003);
        wr(`REG_SET_PERIOD, 32'h0000000A);
        wr(`REG_CHECK_INTERVAL, 32'h00000001);
        wr(`REG_FAIL_THRESHOLD, 32'h00000002);
        run(320, 8'h02);
        chk(point_invalid_q, 8'h01);
        rd(`REG_INVALID, 32'h00000001);
        run(60, 8'h03);
        chk(point_invalid_q, 8'h00);
        wr(`REG_FAIL_THRESHOLD, 32'h00000000);
        run(440, 8'h00);
        chk(point_invalid_q, 8'h00);
        finish_test();
    end
endmodule // tb_event_priority_validity_monitor
`default_nettype wire
